// *** common/mps_pkg.sv ***
/*
 * Shared constants and types of the measurement pipeline sequencer:
 * measuring rates, cycle periods, pipeline stage positions and the
 * configuration and result carriers.
 * Assumes a 10 MHz core clock.
 */
package mps_pkg;

  localparam int CLK_PERIOD_NS = 100;

  // Measuring period per rate, in ns
  localparam int RATE_49K_NS = 20350;
  localparam int RATE_30K_NS = 33333;
  localparam int RATE_20K_NS = 50000;
  localparam int RATE_10K_NS = 100000;
  localparam int RATE_5K_NS  = 200000;
  localparam int RATE_2K5_NS = 400000;
  localparam int RATE_1K5_NS = 666667;

  localparam int CNT_W = 16;

  // Period lengths in core cycles, rounded down
  localparam logic [CNT_W-1:0] RATE_49K_CYC = CNT_W'(RATE_49K_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RATE_30K_CYC = CNT_W'(RATE_30K_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RATE_20K_CYC = CNT_W'(RATE_20K_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RATE_10K_CYC = CNT_W'(RATE_10K_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RATE_5K_CYC  = CNT_W'(RATE_5K_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RATE_2K5_CYC = CNT_W'(RATE_2K5_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RATE_1K5_CYC = CNT_W'(RATE_1K5_NS / CLK_PERIOD_NS);

  // Pipeline stage positions
  localparam int STAGES  = 5;
  localparam int STG_EXP = 0;
  localparam int STG_RD  = 1;
  localparam int STG_C1  = 2;
  localparam int STG_C2  = 3;
  localparam int STG_OUT = 4;

  localparam int MEAS_W      = 16;
  localparam int AVG_LOG2_W  = 3;
  localparam int AVG_MAX_LOG2 = 4;

  typedef enum logic [2:0] {
    MPS_RATE_49K = 3'h0,
    MPS_RATE_30K = 3'h1,
    MPS_RATE_20K = 3'h2,
    MPS_RATE_10K = 3'h3,
    MPS_RATE_5K  = 3'h4,
    MPS_RATE_2K5 = 3'h5,
    MPS_RATE_1K5 = 3'h6
  } mps_rate_t;

  typedef struct packed {
    mps_rate_t             rate;
    logic                  avg_en;
    logic [AVG_LOG2_W-1:0] avg_log2;
  } mps_cfg_t;

  typedef struct packed {
    logic [MEAS_W-1:0] value;
    logic              settled;
  } mps_meas_t;

  localparam mps_cfg_t CFG_RST = '{rate: MPS_RATE_49K, avg_en: 1'b0, avg_log2: 3'h0};

endpackage : mps_pkg

// *** logic/mps_avg.sv ***
/*
 * Moving average over the last 2**avg_log2 values, fixed two-cycle
 * latency whether averaging is on or off.
 * Assumes in_valid pulses no closer than three cycles apart.
 */
`timescale 1ns/1ns
`default_nettype none

module mps_avg #(
  parameter int DATA_W     = mps_pkg::MEAS_W,
  parameter int DEPTH_LOG2 = mps_pkg::AVG_MAX_LOG2
) (
  input  wire logic                                core_clk,
  input  wire logic                                rst_b,
  input  wire logic                                clk_en,
  input  wire logic                                avg_en,
  input  wire logic [mps_pkg::AVG_LOG2_W-1:0]      avg_log2,
  input  wire logic                                clear,
  input  wire logic                                in_valid,
  input  wire logic [DATA_W-1:0]                   in_data,
  output logic                                     out_valid,
  output logic [DATA_W-1:0]                        out_data,
  output logic                                     out_settled
);

  localparam int SUM_W = DATA_W + DEPTH_LOG2;
  localparam int FILL_W = DEPTH_LOG2 + 1;

  logic [DATA_W-1:0]     mem [2**DEPTH_LOG2];
  logic [DATA_W-1:0]     old_q;
  logic [DATA_W-1:0]     new_q, new_d;
  logic [DEPTH_LOG2-1:0] wr_ptr_q, wr_ptr_d;
  logic [FILL_W-1:0]     fill_q, fill_d;
  logic [SUM_W-1:0]      sum_q, sum_d;
  logic                  pend_q, pend_d;
  logic                  out_valid_q, out_valid_d;
  logic [DATA_W-1:0]     out_data_q, out_data_d;
  logic                  settled_q, settled_d;
  logic [FILL_W-1:0]     win;
  logic [DEPTH_LOG2-1:0] rd_addr;

  assign win     = FILL_W'(1) << avg_log2;
  assign rd_addr = wr_ptr_q - win[DEPTH_LOG2-1:0];

  always_comb begin
    new_d       = new_q;
    wr_ptr_d    = wr_ptr_q;
    fill_d      = fill_q;
    sum_d       = sum_q;
    pend_d      = in_valid;
    out_valid_d = pend_q;
    out_data_d  = out_data_q;
    settled_d   = settled_q;
    if (in_valid) begin
      new_d = in_data;
    end
    if (pend_q) begin
      // Window full: the oldest value drops out as the newest enters
      sum_d = sum_q + SUM_W'(new_q) - ((fill_q >= win) ? SUM_W'(old_q) : '0);
      if (fill_q < win) begin
        fill_d = fill_q + FILL_W'(1);
      end
      wr_ptr_d = wr_ptr_q + DEPTH_LOG2'(1);
      out_data_d = avg_en ? DATA_W'(sum_d >> avg_log2) : new_q;
      settled_d  = !avg_en || (fill_d >= win);
    end
    if (clear) begin
      fill_d    = '0;
      sum_d     = '0;
      settled_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      new_q       <= '0;
      wr_ptr_q    <= '0;
      fill_q      <= '0;
      sum_q       <= '0;
      pend_q      <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
      settled_q   <= 1'b0;
    end else if (clk_en) begin
      new_q       <= new_d;
      wr_ptr_q    <= wr_ptr_d;
      fill_q      <= fill_d;
      sum_q       <= sum_d;
      pend_q      <= pend_d;
      out_valid_q <= out_valid_d;
      out_data_q  <= out_data_d;
      settled_q   <= settled_d;
    end
  end

  // History store, registered read
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      old_q <= mem[rd_addr];
      if (pend_q) begin
        mem[wr_ptr_q] <= new_q;
      end
    end
  end

  assign out_valid   = out_valid_q;
  assign out_data    = out_data_q;
  // Averaging off passes every value through as settled
  assign out_settled = settled_q || !avg_en;

  property p_fixed_lat;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      in_valid |-> ##2 out_valid_q;
  endproperty
  a_fixed_lat: assert property (p_fixed_lat) else $error("Average latency not two cycles");

  property p_settle;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      (settled_q && avg_en && !$changed(avg_log2)) |-> (fill_q >= win);
  endproperty
  a_settle: assert property (p_settle) else $error("Settled before window filled");

endmodule : mps_avg

`default_nettype wire

// *** logic/mps_sequencer.sv ***
/*
 * Measurement pipeline sequencer: five-stage overlapped pipeline
 * (exposure, readout, two compute cycles, output) paced by the
 * selected measuring rate, with configuration and persistent save.
 * Assumes link command parsers and the persistent store sit on
 * core_clk and deliver one-cycle strobes.
 */
// How it works
// - Each measurement passes exposure, readout, two compute cycles, then output.
// - One pipeline cycle equals one measuring period of the selected rate.
// - One value leaves per period, exactly five periods after its exposure.
// - Stages of successive measurements run concurrently; output never stalls.
// - Averaging keeps latency and cadence; results settle after the count fills.
// - Configuration arrives from serial and network links; host uses valid settings.
// - Unsaved changes are lost at power-off; saved settings return at power-up.
`timescale 1ns/1ns
`default_nettype none

module mps_sequencer #(
  parameter logic [mps_pkg::CNT_W-1:0] RATE_1K5_CYC = mps_pkg::RATE_1K5_CYC
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic                         clk_en,
  input  wire logic                         ser_cfg_wr,
  input  wire mps_pkg::mps_cfg_t            ser_cfg,
  input  wire logic                         net_cfg_wr,
  input  wire mps_pkg::mps_cfg_t            net_cfg,
  input  wire logic                         cfg_save,
  input  wire mps_pkg::mps_cfg_t            nvm_cfg,
  output logic                              nvm_wr,
  output mps_pkg::mps_cfg_t                 nvm_wr_data,
  output mps_pkg::mps_cfg_t                 cfg_active,
  output logic                              expose,
  output logic                              readout,
  input  wire logic                         det_valid,
  input  wire logic [mps_pkg::MEAS_W-1:0]   det_data,
  output logic                              meas_valid,
  output mps_pkg::mps_meas_t                meas_data
);

  localparam int CW = mps_pkg::CNT_W;

  function automatic logic [CW-1:0] rate_cycles(input mps_pkg::mps_rate_t r);
    unique case (r)
      mps_pkg::MPS_RATE_49K: rate_cycles = mps_pkg::RATE_49K_CYC;
      mps_pkg::MPS_RATE_30K: rate_cycles = mps_pkg::RATE_30K_CYC;
      mps_pkg::MPS_RATE_20K: rate_cycles = mps_pkg::RATE_20K_CYC;
      mps_pkg::MPS_RATE_10K: rate_cycles = mps_pkg::RATE_10K_CYC;
      mps_pkg::MPS_RATE_5K:  rate_cycles = mps_pkg::RATE_5K_CYC;
      mps_pkg::MPS_RATE_2K5: rate_cycles = mps_pkg::RATE_2K5_CYC;
      mps_pkg::MPS_RATE_1K5: rate_cycles = RATE_1K5_CYC;
      default:               rate_cycles = mps_pkg::RATE_49K_CYC;
    endcase
  endfunction : rate_cycles

  // Configuration group
  mps_pkg::mps_cfg_t cfg_q, cfg_d;
  mps_pkg::mps_cfg_t nvm_data_q, nvm_data_d;
  logic              nvm_wr_q, nvm_wr_d;
  logic              boot_q, boot_d;
  logic              avg_clear;

  always_comb begin
    cfg_d      = cfg_q;
    boot_d     = 1'b0;
    nvm_wr_d   = cfg_save && !boot_q;
    nvm_data_d = nvm_data_q;
    if (cfg_save && !boot_q) begin
      nvm_data_d = cfg_q;
    end
    if (boot_q) begin
      cfg_d = nvm_cfg;
    end else if (ser_cfg_wr) begin
      cfg_d = ser_cfg;
    end else if (net_cfg_wr) begin
      cfg_d = net_cfg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q      <= mps_pkg::CFG_RST;
      boot_q     <= 1'b1;
      nvm_wr_q   <= 1'b0;
      nvm_data_q <= mps_pkg::CFG_RST;
    end else if (clk_en) begin
      cfg_q      <= cfg_d;
      boot_q     <= boot_d;
      nvm_wr_q   <= nvm_wr_d;
      nvm_data_q <= nvm_data_d;
    end
  end

  // Averaging restarts when its setup changes
  assign avg_clear = (cfg_d.avg_en != cfg_q.avg_en) || (cfg_d.avg_log2 != cfg_q.avg_log2);

  // Sequencer group
  logic [CW-1:0]                cnt_q, cnt_d;
  logic [CW-1:0]                period_q, period_d;
  logic [mps_pkg::STAGES-1:0]   stg_q, stg_d;
  logic                         expose_q, expose_d;
  logic                         readout_q, readout_d;
  logic [mps_pkg::MEAS_W-1:0]   raw_q, raw_d;
  mps_pkg::mps_meas_t           c2_q, c2_d;
  mps_pkg::mps_meas_t           out_q, out_d;
  mps_pkg::mps_meas_t           meas_q, meas_d;
  logic                         meas_valid_q, meas_valid_d;
  logic                         tick;
  logic                         avg_in_valid;
  logic [mps_pkg::MEAS_W-1:0]   avg_data;
  logic                         avg_settled;

  assign tick         = (cnt_q == period_q - CW'(1));
  assign avg_in_valid = tick && stg_q[mps_pkg::STG_RD];

  always_comb begin
    cnt_d        = tick ? '0 : cnt_q + CW'(1);
    // Rate changes take effect at a period boundary only
    period_d     = tick ? rate_cycles(cfg_q.rate) : period_q;
    stg_d        = stg_q;
    expose_d     = 1'b0;
    readout_d    = 1'b0;
    raw_d        = raw_q;
    c2_d         = c2_q;
    out_d        = out_q;
    meas_d       = meas_q;
    meas_valid_d = 1'b0;
    if (det_valid && stg_q[mps_pkg::STG_RD]) begin
      raw_d = det_data;
    end
    if (tick) begin
      stg_d     = {stg_q[mps_pkg::STAGES-2:0], !boot_q};
      expose_d  = !boot_q;
      readout_d = stg_q[mps_pkg::STG_EXP];
      if (stg_q[mps_pkg::STG_C1]) begin
        c2_d = '{value: avg_data, settled: avg_settled};
      end
      out_d = c2_q;
      // value leaves five periods after exposure
      meas_d       = out_q;
      meas_valid_d = stg_q[mps_pkg::STG_OUT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q        <= '0;
      period_q     <= mps_pkg::RATE_49K_CYC;
      stg_q        <= '0;
      expose_q     <= 1'b0;
      readout_q    <= 1'b0;
      raw_q        <= '0;
      c2_q         <= '0;
      out_q        <= '0;
      meas_q       <= '0;
      meas_valid_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q        <= cnt_d;
      period_q     <= period_d;
      stg_q        <= stg_d;
      expose_q     <= expose_d;
      readout_q    <= readout_d;
      raw_q        <= raw_d;
      c2_q         <= c2_d;
      out_q        <= out_d;
      meas_q       <= meas_d;
      meas_valid_q <= meas_valid_d;
    end
  end

  mps_avg #(
    .DATA_W     (mps_pkg::MEAS_W),
    .DEPTH_LOG2 (mps_pkg::AVG_MAX_LOG2)
  ) u_avg (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .avg_en      (cfg_q.avg_en),
    .avg_log2    (cfg_q.avg_log2),
    .clear       (avg_clear),
    .in_valid    (avg_in_valid),
    .in_data     (raw_q),
    .out_valid   (),
    .out_data    (avg_data),
    .out_settled (avg_settled)
  );

  assign nvm_wr      = nvm_wr_q;
  assign nvm_wr_data = nvm_data_q;
  assign cfg_active  = cfg_q;
  assign expose      = expose_q;
  assign readout     = readout_q;
  assign meas_valid  = meas_valid_q;
  assign meas_data   = meas_q;

  // Cycles since the last exposure pulse, for checking only
  logic [CW-1:0] gap_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= '0;
    end else if (clk_en) begin
      gap_q <= expose_q ? CW'(1) : gap_q + CW'(1);
    end
  end

  property p_exp_rd;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      (tick && stg_q[mps_pkg::STG_EXP]) |=> readout_q;
  endproperty
  a_exp_rd: assert property (p_exp_rd) else $error("Readout did not follow exposure");

  property p_period;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      (expose_q && $stable(period_q)) |-> (gap_q == period_q);
  endproperty
  a_period: assert property (p_period) else $error("Period length wrong");

  property p_latency;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      meas_valid_q |-> ($past(stg_q[mps_pkg::STG_OUT]) && $past(tick));
  endproperty
  a_latency: assert property (p_latency) else $error("Output not from fifth stage");

  property p_no_stall;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      (tick && !boot_q) |=> (stg_q[mps_pkg::STG_EXP] && expose_q);
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("Pipeline stalled");

  property p_cfg_take;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      (ser_cfg_wr && !boot_q) |=> (cfg_q == $past(ser_cfg));
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("Serial setting not taken");

  property p_save;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      (cfg_save && !boot_q) |=> (nvm_wr_q && nvm_data_q == $past(cfg_q));
  endproperty
  a_save: assert property (p_save) else $error("Save did not write active set");

  property p_restore;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      (rst_b && boot_q) |=> (cfg_q == $past(nvm_cfg) && !boot_q);
  endproperty
  a_restore: assert property (p_restore) else $error("Saved set not restored");

  property p_strobe;
    @(posedge core_clk) disable iff (!rst_b || !clk_en)
      meas_valid_q |=> !meas_valid_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Valid strobe longer than one cycle");

endmodule : mps_sequencer

`default_nettype wire

// *** dv/mps_far_model.sv ***
/* Far-side model: detector front end and persistent settings store.
   Assumes readout and nvm_wr are one-cycle pulses on core_clk. */
`timescale 1ns/1ns
`default_nettype none
module mps_far_model #(
  parameter mps_pkg::mps_cfg_t BOOT_CFG = mps_pkg::CFG_RST
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  readout,
  input  wire logic                  nvm_wr,
  input  wire mps_pkg::mps_cfg_t     nvm_wr_data,
  output logic                       det_valid,
  output logic [mps_pkg::MEAS_W-1:0] det_data,
  output mps_pkg::mps_cfg_t          nvm_cfg
);
  logic [15:0] rd_cnt_q;
  logic [1:0]  dly_q;
  initial nvm_cfg = BOOT_CFG;
  always @(posedge core_clk) begin
    if (nvm_wr) nvm_cfg <= nvm_wr_data;
  end
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_cnt_q  <= 16'h0000;
      dly_q     <= 2'h0;
      det_valid <= 1'b0;
      det_data  <= 16'h5a5a;
    end else begin
      det_valid <= 1'b0;
      // Idle data toggles so a stale value never passes
      det_data  <= ~det_data;
      dly_q     <= readout ? 2'h3 : ((dly_q == 2'h0) ? 2'h0 : dly_q - 2'h1);
      if (dly_q == 2'h1) begin
        det_valid <= 1'b1;
        det_data  <= 16'h1000 + rd_cnt_q;
        rd_cnt_q  <= rd_cnt_q + 16'h0001;
      end
    end
  end
endmodule : mps_far_model
`default_nettype wire

// *** dv/measurement_pipeline_sequencer_bench.sv ***
/* Self-checking bench of the measurement pipeline sequencer.
   Assumes the far-side model and a 20-cycle slowest-rate period. */
`timescale 1ns/1ns
`default_nettype none
module measurement_pipeline_sequencer_bench;
  localparam logic [15:0] P6 = 16'h0014;
  localparam mps_pkg::mps_cfg_t BOOT = '{rate: mps_pkg::MPS_RATE_1K5, avg_en: 1'b0,
                                          avg_log2: 3'h0};
  logic               core_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               clk_en = 1'b1;
  logic               ser_cfg_wr = 1'b0;
  logic               net_cfg_wr = 1'b0;
  logic               cfg_save = 1'b0;
  mps_pkg::mps_cfg_t  ser_cfg = mps_pkg::CFG_RST;
  mps_pkg::mps_cfg_t  net_cfg = mps_pkg::CFG_RST;
  mps_pkg::mps_cfg_t  nvm_cfg, nvm_wr_data, cfg_active;
  logic               nvm_wr, expose, readout, det_valid, meas_valid;
  logic [15:0]        det_data;
  mps_pkg::mps_meas_t meas_data;
  int                 fails = 0, checks_done = 0, cyc = 0, rd_n = 0, last_mv = 0, n_mv = 0;
  int                 cur_p = 20;
  bit                 chk_lat = 0, avg_on = 0, prev_mv = 0;
  logic [15:0]        avg_sub = 16'h0001;
  int                 t_q[$];
  logic [15:0]        v_q[$];
  int                 per[8] = '{int'(mps_pkg::RATE_49K_CYC), int'(mps_pkg::RATE_30K_CYC),
                                 int'(mps_pkg::RATE_20K_CYC), int'(mps_pkg::RATE_10K_CYC),
                                 int'(mps_pkg::RATE_5K_CYC), int'(mps_pkg::RATE_2K5_CYC),
                                 20, int'(mps_pkg::RATE_49K_CYC)};

  always #50 core_clk = ~core_clk;

  mps_sequencer #(.RATE_1K5_CYC(P6)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .ser_cfg_wr(ser_cfg_wr),
    .ser_cfg(ser_cfg), .net_cfg_wr(net_cfg_wr), .net_cfg(net_cfg), .cfg_save(cfg_save),
    .nvm_cfg(nvm_cfg), .nvm_wr(nvm_wr), .nvm_wr_data(nvm_wr_data), .cfg_active(cfg_active),
    .expose(expose), .readout(readout), .det_valid(det_valid), .det_data(det_data),
    .meas_valid(meas_valid), .meas_data(meas_data));

  mps_far_model #(.BOOT_CFG(BOOT)) far (
    .core_clk(core_clk), .rst_b(rst_b), .readout(readout), .nvm_wr(nvm_wr),
    .nvm_wr_data(nvm_wr_data), .det_valid(det_valid), .det_data(det_data), .nvm_cfg(nvm_cfg));

  task automatic results;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic miss(input string m);
    fails++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : miss

  task automatic chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) miss("flag");
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) miss("value");
  endtask : chk_word

  task automatic chk_cfg(input mps_pkg::mps_cfg_t g, input mps_pkg::mps_cfg_t e);
    checks_done++;
    if (g !== e) miss("config");
  endtask : chk_cfg

  task automatic chk_num(input int g, input int e);
    checks_done++;
    if (g != e) miss("cycles");
  endtask : chk_num

  function automatic mps_pkg::mps_cfg_t mk(input logic [2:0] r, input logic a,
                                           input logic [2:0] l);
    mk = '{rate: mps_pkg::mps_rate_t'(r), avg_en: a, avg_log2: l};
  endfunction : mk

  task automatic wr_cfg(input logic s, input logic n, input mps_pkg::mps_cfg_t sv,
                        input mps_pkg::mps_cfg_t nv);
    @(posedge core_clk);
    ser_cfg_wr <= s;
    ser_cfg    <= sv;
    net_cfg_wr <= n;
    net_cfg    <= nv;
    @(posedge core_clk);
    ser_cfg_wr <= 1'b0;
    net_cfg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr_cfg

  task automatic wait_exp(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (expose !== 1'b1 && n < 5000);
    if (n >= 5000) miss("no exposure");
  endtask : wait_exp

  task automatic wait_mv;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (meas_valid !== 1'b1 && n < 5000);
    if (n >= 5000) miss("no value strobe");
  endtask : wait_mv

  task automatic do_reset(input mps_pkg::mps_cfg_t exp);
    @(posedge core_clk);
    rst_b   <= 1'b0;
    chk_lat = 0;
    repeat (10) @(posedge core_clk);
    chk_cfg(cfg_active, mps_pkg::CFG_RST);
    chk_bit(meas_valid, 1'b0);
    // Strobe in the boot cycle must be dropped
    ser_cfg    <= mps_pkg::mps_cfg_t'(7'h2a);
    ser_cfg_wr <= 1'b1;
    rst_b      <= 1'b1;
    @(posedge core_clk);
    ser_cfg_wr <= 1'b0;
    @(posedge core_clk);
    chk_cfg(cfg_active, exp);
  endtask : do_reset

  task automatic sc_cfg;
    wr_cfg(1'b1, 1'b0, mk(3'h6, 1'b0, 3'h2), BOOT);
    chk_cfg(cfg_active, mk(3'h6, 1'b0, 3'h2));
    wr_cfg(1'b0, 1'b1, BOOT, mk(3'h6, 1'b0, 3'h4));
    chk_cfg(cfg_active, mk(3'h6, 1'b0, 3'h4));
    wr_cfg(1'b1, 1'b1, BOOT, mk(3'h6, 1'b0, 3'h3));
    chk_cfg(cfg_active, BOOT);
  endtask : sc_cfg

  task automatic sc_save;
    wr_cfg(1'b1, 1'b0, mk(3'h6, 1'b0, 3'h3), BOOT);
    @(posedge core_clk);
    cfg_save   <= 1'b1;
    ser_cfg_wr <= 1'b1;
    ser_cfg    <= BOOT;
    @(posedge core_clk);
    cfg_save   <= 1'b0;
    ser_cfg_wr <= 1'b0;
    @(posedge core_clk);
    chk_bit(nvm_wr, 1'b1);
    chk_cfg(nvm_wr_data, mk(3'h6, 1'b0, 3'h3));
    chk_cfg(cfg_active, BOOT);
    @(posedge core_clk);
    chk_bit(nvm_wr, 1'b0);
    do_reset(mk(3'h6, 1'b0, 3'h3));
  endtask : sc_save

  task automatic sc_pipe;
    int n0;
    cur_p = 20;
    repeat (400) @(posedge core_clk);
    chk_lat = 1;
    wait_mv;
    n0 = n_mv;
    repeat (200) @(posedge core_clk);
    chk_num(n_mv - n0, 10);
  endtask : sc_pipe

  task automatic sc_rate;
    int n;
    chk_lat = 0;
    for (int c = 0; c < 8; c++) begin
      wr_cfg(1'b1, 1'b0, mk(3'(c), 1'b0, 3'h0), BOOT);
      wait_exp(n);
      wait_exp(n);
      wait_exp(n);
      chk_num(n, per[c]);
    end
  endtask : sc_rate

  task automatic sc_avg;
    int n0;
    avg_on = 1;
    wr_cfg(1'b1, 1'b0, mk(3'h6, 1'b1, 3'h1), BOOT);
    repeat (600) @(posedge core_clk);
    chk_lat = 1;
    wait_mv;
    n0 = n_mv;
    repeat (200) @(posedge core_clk);
    chk_num(n_mv - n0, 10);
    // Widest window: sixteen consecutive values average to newest minus eight
    @(posedge core_clk);
    chk_lat = 0;
    avg_sub = 16'h0008;
    wr_cfg(1'b1, 1'b0, mk(3'h6, 1'b1, 3'h4), BOOT);
    repeat (600) @(posedge core_clk);
    chk_lat = 1;
    wait_mv;
    n0 = n_mv;
    repeat (200) @(posedge core_clk);
    chk_num(n_mv - n0, 10);
  endtask : sc_avg

  task automatic sc_freeze;
    mps_pkg::mps_meas_t held;
    chk_lat = 0;
    wait_mv;
    clk_en <= 1'b0;
    @(posedge core_clk);
    held = meas_data;
    repeat (60) @(posedge core_clk);
    chk_word(meas_data.value, held.value);
    chk_bit(meas_valid, 1'b0);
    clk_en <= 1'b1;
    // Frozen cycles do not count toward the period
    repeat (cur_p - 1) @(posedge core_clk);
    chk_bit(meas_valid, 1'b0);
    @(posedge core_clk);
    chk_bit(meas_valid, 1'b1);
  endtask : sc_freeze

  // Scoreboard: expose times and detector values, oldest first
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 50000) begin
      miss("timeout");
      results;
    end else if (!rst_b) begin
      t_q.delete();
      v_q.delete();
      rd_n = 0;
      last_mv = 0;
      prev_mv = 0;
    end else if (clk_en) begin
      if (expose) t_q.push_back(cyc);
      if (readout) v_q.push_back(16'h1000 + 16'(rd_n));
      if (readout) rd_n++;
      if (chk_lat && readout) chk_bit(expose, 1'b1);
      if (meas_valid) begin
        chk_bit(prev_mv, 1'b0);
        if (chk_lat) chk_num(cyc - t_q[0], 5 * cur_p);
        if (chk_lat) chk_num(cyc - last_mv, cur_p);
        if (!avg_on) chk_word(meas_data.value, v_q[0]);
        if (!avg_on) chk_bit(meas_data.settled, 1'b1);
        if (avg_on && chk_lat) chk_word(meas_data.value, v_q[0] - avg_sub);
        if (avg_on && chk_lat) chk_bit(meas_data.settled, 1'b1);
        last_mv = cyc;
        n_mv <= n_mv + 1;
        void'(t_q.pop_front());
        void'(v_q.pop_front());
      end
      prev_mv = meas_valid;
    end
  end

  initial begin
    do_reset(BOOT);
    sc_cfg;
    sc_save;
    sc_pipe;
    sc_rate;
    sc_avg;
    sc_freeze;
    results;
  end
endmodule : measurement_pipeline_sequencer_bench
`default_nettype wire
